// ==== swb_master.sv ====
// single-wire bus master: reset/presence, write slots, read slots
//
// Contract
// - two speeds, 1 us and 0.2 us time base; all timing scales. Code scales slots by five but reset low by ten (480 to 48 us).
// - master opens with reset low, 480 us standard or 48 us high.
// - after reset low, master releases the line for the pull-up.
// - slaves wait 15-60 us then drive presence low 60-240 us.
// - each period opens with reset; every slave answers with presence.
// - write or read slots only after presence followed the reset.
// - write slot starts with high-to-low; carries a 0 or a 1.
// - slot lasts at least 60 us, then at least 1 us recovery.
// - slave samples 15-60 us after falling edge; low is 0.
// - read slot starts with low held at least 1 us.
// - slave places read bit within 14 us of slot start.
// - master releases and samples the line from 15 us on.
// - 64-bit id: family byte, 48-bit serial, CRC byte on top.
`timescale 1ns/1ps
module swb_master
   import swb_pkg::*;
#(
   parameter logic [13:0] RST_STD_CYC = RSTL_STD_CYC
)
(
   // clock, reset, enable
   input  wire logic              mclk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              ce_in,
   // command port
   input  wire logic              cmd_valid_in,
   output logic                   cmd_ready_out,
   input  wire swb_cmd_t          cmd_in,
   // read words
   output logic                   rd_valid_out,
   input  wire logic              rd_ready_in,
   output logic [WORD_W-1:0]      rd_data_out,
   // status
   output logic                   presence_out,
   output logic                   done_out,
   output logic                   err_out,
   // bus data line, open drain
   input  wire logic              line_in,
   output logic                   line_out,
   output logic                   line_oe_out
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_RLOW, ST_RREL, ST_SLOW, ST_SHI, ST_REC} swb_st_t;

   swb_st_t           state_r;
   swb_cmd_t          cmd_r;
   logic [13:0]       cnt_r;
   logic [13:0]       age_r;
   logic [5:0]        idx_r;
   logic [WORD_W-1:0] word_r;
   logic              present_r;
   logic              done_r;
   logic              err_r;
   logic              sync1_r;
   logic              sync2_r;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire        hs        = cmd_r.high_speed;
   wire [13:0] rst_len   = hs ? RSTL_HS_CYC : RST_STD_CYC;
   wire [13:0] acc_rst   = cmd_in.high_speed ? RSTL_HS_CYC : RST_STD_CYC;
   wire [13:0] slot_len  = hs ? SLOT_HS_CYC : SLOT_STD_CYC;
   wire [13:0] low_len   = hs ? LOW_HS_CYC : LOW_STD_CYC;
   wire [13:0] samp_len  = hs ? SAMP_HS_CYC : SAMP_STD_CYC;
   wire [13:0] rec_len   = hs ? REC_HS_CYC : REC_STD_CYC;
   wire        is_read   = (cmd_r.op == SWB_OP_READ);
   wire        line_s    = sync2_r;
   wire [5:0]  tx_pos    = cmd_r.msb_first ? (cmd_r.len - 6'h1 - idx_r) : idx_r;
   wire        tx_bit    = cmd_r.data[tx_pos[4:0]];
   wire        buf_ready;
   wire        len_ok    = (cmd_in.len != 6'h0) && (cmd_in.len <= LEN_MAX);
   wire        acc       = ce_in && cmd_valid_in && cmd_ready_out;
   wire        acc_rst_c = acc && (cmd_in.op == SWB_OP_RESET);
   wire        acc_ok    = acc && (cmd_in.op != SWB_OP_RESET) && present_r && len_ok
                           && (cmd_in.op != SWB_OP_READ || buf_ready);
   wire        samp_en   = ce_in && (state_r == ST_SHI) && is_read && (age_r == samp_len);
   wire        last_bit  = (idx_r + 6'h1 == cmd_r.len);
   wire        slot_end  = ce_in && (state_r == ST_REC) && (cnt_r == 14'h0);
   wire        push      = slot_end && last_bit && is_read;
   // skip two cycles: the synchroniser still shows the master's own low
   wire        listen    = (state_r == ST_RREL) && (cnt_r <= rst_len - 14'h3);
   wire [WORD_W-1:0] word_nxt = cmd_r.msb_first ? {word_r[WORD_W-2:0], line_s}
                                                : (word_r | ({31'h0, line_s} << idx_r[4:0]));

   assign cmd_ready_out = (state_r == ST_IDLE);
   assign line_out      = 1'b0;
   assign line_oe_out   = (state_r == ST_RLOW) || (state_r == ST_SLOW)
                          || (state_r == ST_SHI && !is_read && !tx_bit);
   assign presence_out  = present_r;
   assign done_out      = done_r;
   assign err_out       = err_r;

   // ----------------------------------------
   // line synchroniser
   // ----------------------------------------
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end
      else if (ce_in)
      begin
         sync1_r <= line_in;
         sync2_r <= sync1_r;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         state_r   <= ST_IDLE;
         cmd_r     <= '0;
         cnt_r     <= 14'h0;
         age_r     <= 14'h0;
         idx_r     <= 6'h0;
         word_r    <= '0;
         present_r <= 1'b0;
         done_r    <= 1'b0;
         err_r     <= 1'b0;
      end
      else if (ce_in)
      begin
         done_r <= 1'b0;
         err_r  <= 1'b0;
         age_r  <= age_r + 14'h1;
         case (state_r)
            ST_IDLE:
            begin
               if (acc_rst_c)
               begin
                  cmd_r     <= cmd_in;
                  present_r <= 1'b0;
                  cnt_r     <= acc_rst - 14'h1;
                  state_r   <= ST_RLOW;
               end
               else if (acc_ok)
               begin
                  cmd_r   <= cmd_in;
                  idx_r   <= 6'h0;
                  word_r  <= '0;
                  age_r   <= 14'h0;
                  state_r <= ST_SLOW;
               end
               else if (acc)
                  err_r <= 1'b1;
            end
            ST_RLOW:
            begin
               cnt_r <= cnt_r - 14'h1;
               if (cnt_r == 14'h0)
               begin
                  cnt_r   <= rst_len - 14'h1;
                  state_r <= ST_RREL;
               end
            end
            ST_RREL:
            begin
               cnt_r <= cnt_r - 14'h1;
               if (listen && !line_s)
                  present_r <= 1'b1;
               if (cnt_r == 14'h0)
               begin
                  done_r  <= 1'b1;
                  state_r <= ST_IDLE;
               end
            end
            ST_SLOW:
            begin
               if (age_r == low_len - 14'h1)
                  state_r <= ST_SHI;
            end
            ST_SHI:
            begin
               if (samp_en)
                  word_r <= word_nxt;
               if (age_r == slot_len - 14'h1)
               begin
                  cnt_r   <= rec_len - 14'h1;
                  state_r <= ST_REC;
               end
            end
            ST_REC:
            begin
               cnt_r <= cnt_r - 14'h1;
               if (cnt_r == 14'h0)
               begin
                  idx_r <= idx_r + 6'h1;
                  age_r <= 14'h0;
                  if (last_bit)
                  begin
                     done_r  <= 1'b1;
                     state_r <= ST_IDLE;
                  end
                  else
                     state_r <= ST_SLOW;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // read word buffer
   // ----------------------------------------
   swb_buf u_buf (
      .mclk_in       (mclk_in),
      .sys_rst_in    (sys_rst_in),
      .ce_in         (ce_in),
      .in_valid_in   (push),
      .in_ready_out  (buf_ready),
      .in_data_in    (word_r),
      .out_valid_out (rd_valid_out),
      .out_ready_in  (rd_ready_in),
      .out_data_out  (rd_data_out)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [13:0] run_r;

   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         run_r <= 14'h0;
      else if (ce_in)
         run_r <= line_oe_out ? run_r + 14'h1 : 14'h0;
   end

   a_reset_low_len: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (ce_in && state_r == ST_RLOW && cnt_r == 14'h0) |-> (run_r == rst_len - 14'h1))
      else $error("reset low time wrong");

   a_reset_release: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (ce_in && state_r == ST_RLOW && cnt_r == 14'h0) |=> !line_oe_out [*2])
      else $error("line not released after reset");

   a_slot_low_min: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      ($rose(line_oe_out) && ce_in && state_r == ST_SLOW) |-> line_oe_out [*5])
      else $error("slot low too short");

   a_slot_gated: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (acc && state_r == ST_IDLE && cmd_in.op != SWB_OP_RESET && !present_r) |=> (state_r == ST_IDLE && err_out))
      else $error("slot started without presence");

   a_slot_length: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (ce_in && state_r == ST_SHI && age_r == slot_len - 14'h1) |=> (state_r == ST_REC && !line_oe_out))
      else $error("slot length wrong");

   a_read_sample: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      samp_en |-> (!line_oe_out && $past(state_r, 1) == ST_SHI && age_r >= SAMP_HS_CYC))
      else $error("read sampled too early or while driving");

   a_write_zero: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (ce_in && state_r == ST_SHI && !is_read && !tx_bit && age_r == slot_len - 14'h1)
      |-> (run_r == slot_len - 14'h1))
      else $error("write zero not held low");

   a_speed_scale: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (acc_rst_c && cmd_in.high_speed) |=> (cnt_r == RSTL_HS_CYC - 14'h1 && state_r == ST_RLOW))
      else $error("high speed reset length wrong");

   a_presence_seen: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (ce_in && listen && !line_s) |=> present_r)
      else $error("presence pulse missed");

endmodule : swb_master

// ==== swb_pkg.sv ====
// constants and types for the single-wire bus master
package swb_pkg;

   // ----------------------------------------
   // clock
   // ----------------------------------------
   localparam int CLK_NS = 40;

   // ----------------------------------------
   // bus timing in ns, per speed
   // ----------------------------------------
   localparam int RSTL_STD_NS = 480000;
   localparam int RSTL_HS_NS  = 48000;
   localparam int SLOT_STD_NS = 60000;
   localparam int SLOT_HS_NS  = 12000;
   localparam int LOW_STD_NS  = 1000;
   localparam int LOW_HS_NS   = 200;
   localparam int SAMP_STD_NS = 15000;
   localparam int SAMP_HS_NS  = 3000;
   localparam int REC_STD_NS  = 1000;
   localparam int REC_HS_NS   = 200;

   // ----------------------------------------
   // cycle counts, least times rounded up
   // ----------------------------------------
   localparam logic [13:0] RSTL_STD_CYC = 14'((RSTL_STD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] RSTL_HS_CYC  = 14'((RSTL_HS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] SLOT_STD_CYC = 14'((SLOT_STD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] SLOT_HS_CYC  = 14'((SLOT_HS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] LOW_STD_CYC  = 14'((LOW_STD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] LOW_HS_CYC   = 14'((LOW_HS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] SAMP_STD_CYC = 14'((SAMP_STD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] SAMP_HS_CYC  = 14'((SAMP_HS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] REC_STD_CYC  = 14'((REC_STD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [13:0] REC_HS_CYC   = 14'((REC_HS_NS + CLK_NS - 1) / CLK_NS);

   // ----------------------------------------
   // word and identification layout
   // ----------------------------------------
   localparam int          WORD_W      = 32;
   localparam logic [5:0]  LEN_MAX     = 6'h20;
   localparam int          ID_FAM_LSB  = 0;
   localparam int          ID_SER_LSB  = 8;
   localparam int          ID_CRC_LSB  = 56;
   localparam logic [1:0]  BUF_DEPTH   = 2'h2;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {SWB_OP_RESET, SWB_OP_WRITE, SWB_OP_READ} swb_op_t;

   typedef struct packed {
      swb_op_t             op;
      logic                high_speed;
      logic                msb_first;
      logic [5:0]          len;
      logic [WORD_W-1:0]   data;
   } swb_cmd_t;

endpackage : swb_pkg

// ==== swb_buf.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module swb_buf
   import swb_pkg::*;
(
   // clock and reset
   input  wire logic              mclk_in,
   input  wire logic              sys_rst_in,
   input  wire logic              ce_in,
   // filling side
   input  wire logic              in_valid_in,
   output logic                   in_ready_out,
   input  wire logic [WORD_W-1:0] in_data_in,
   // draining side
   output logic                   out_valid_out,
   input  wire logic              out_ready_in,
   output logic [WORD_W-1:0]      out_data_out
);

   logic [WORD_W-1:0] head_r;
   logic [WORD_W-1:0] tail_r;
   logic [1:0]        cnt_r;
   logic              push;
   logic              pop;

   assign in_ready_out  = (cnt_r != BUF_DEPTH);
   assign out_valid_out = (cnt_r != 2'h0);
   assign out_data_out  = head_r;
   assign push          = ce_in && in_valid_in && in_ready_out;
   assign pop           = ce_in && out_valid_out && out_ready_in;

   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         head_r <= '0;
         tail_r <= '0;
         cnt_r  <= 2'h0;
      end
      else if (push && !pop)
      begin
         if (cnt_r == 2'h0)
            head_r <= in_data_in;
         else
            tail_r <= in_data_in;
         cnt_r <= cnt_r + 2'h1;
      end
      else if (pop && !push)
      begin
         head_r <= tail_r;
         cnt_r  <= cnt_r - 2'h1;
      end
      else if (pop && push)
      begin
         head_r <= (cnt_r == 2'h1) ? in_data_in : tail_r;
         tail_r <= in_data_in;
      end
   end

endmodule : swb_buf

// ==== swb_slave_model.sv ====
// behavioural slave device answering on the single-wire bus
`timescale 1ns/1ps
module swb_slave_model
#(
   parameter int          PD_WAIT_STD = 40,
   parameter int          PD_LOW_STD  = 100,
   // id value arbitrary; family code in the low byte
   parameter logic [63:0] DEV_ID      = 64'h1122_3344_5566_7788
)
(
   // clock and reset
   input  wire logic   mclk_in,
   input  wire logic   sys_rst_in,
   // scenario controls
   input  wire logic   en_in,
   input  wire logic   hs_in,
   input  wire logic   rd_mode_in,
   // bus data line
   input  wire logic   line_in,
   output logic        pull_out,
   output logic [31:0] wr_q_out
);
   int         low_c;
   int         age;
   int         pd_c;
   int         wt;
   int         lt;
   logic       prev;
   logic       drv0;
   logic [5:0] idx;

   // ----------------------------------------
   // line watcher and responder
   // ----------------------------------------
   always @(posedge mclk_in)
   begin
      wt = hs_in ? 100 : PD_WAIT_STD;
      lt = hs_in ? 300 : PD_LOW_STD;
      if (sys_rst_in)
      begin
         pd_c = 0;
         age = 1 << 20;
         low_c = 0;
         idx = 6'h00;
         drv0 = 1'b0;
         prev = 1'b1;
         pull_out <= 1'b0;
         wr_q_out <= 32'h0000_0000;
      end
      else
      begin
         if (line_in)
         begin
            if (!prev && en_in && low_c >= (hs_in ? 1000 : 150))
            begin
               pd_c = 1;
               idx = 6'h00;
            end
            low_c = 0;
         end
         else
            low_c++;
         if (!line_in && prev && !pull_out && pd_c == 0)
         begin
            age = 0;
            drv0 = rd_mode_in && !DEV_ID[idx];
            idx = rd_mode_in ? idx + 6'h01 : idx;
         end
         else if (age < (1 << 20))
            age++;
         if (pd_c > 0)
            pd_c++;
         if (pd_c > wt + lt)
            pd_c = 0;
         if (!rd_mode_in && age == (hs_in ? 150 : 750))
            wr_q_out <= {wr_q_out[30:0], line_in};
         pull_out <= (pd_c > wt && pd_c <= wt + lt) || (drv0 && age < (hs_in ? 200 : 1000));
         prev = line_in;
      end
   end

endmodule : swb_slave_model

// ==== tb_single_wire_bus_decoder.sv ====
// self-checking bench for the single-wire bus master
`timescale 1ns/1ps
module tb_single_wire_bus_decoder;
   import swb_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   localparam logic [13:0] RST_CYC = 14'h00C8;
   localparam logic [63:0] DEV_ID  = 64'h5A3C_9E17_4B2D_6F81;
   logic              mclk_in, sys_rst_in, cmd_valid_in, rd_ready_in, en, hs, rd_mode, pull;
   logic              cmd_ready_out, rd_valid_out, presence_out, done_out, err_out, line_out, line_oe_out;
   logic              got_done, got_err;
   logic [WORD_W-1:0] rd_data_out;
   logic [31:0]       wr_q;
   swb_cmd_t          cmd_in;
   int                fails, checked, cyc, oe_cnt;
   wire logic         line = !(line_oe_out && !line_out) && !pull;

   swb_master #(.RST_STD_CYC(RST_CYC)) swb_master_inst (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
      .ce_in(1'b1), .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_in(cmd_in),
      .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in), .rd_data_out(rd_data_out),
      .presence_out(presence_out), .done_out(done_out), .err_out(err_out), .line_in(line),
      .line_out(line_out), .line_oe_out(line_oe_out));
   swb_slave_model #(.PD_WAIT_STD(40), .PD_LOW_STD(100), .DEV_ID(DEV_ID)) swb_slave_model_inst (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .en_in(en), .hs_in(hs), .rd_mode_in(rd_mode),
      .line_in(line), .pull_out(pull), .wr_q_out(wr_q));

   always #20 mclk_in = ~mclk_in;

   always @(posedge mclk_in)
   begin
      cyc++;
      if (cyc >= 80000)
      begin
         fails++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   function automatic logic [31:0] exp_wr(input logic [31:0] d, input int len, input logic msb);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int i = 0; i < len; i++)
         r = {r[30:0], msb ? d[len - 1 - i] : d[i]};
      return r;
   endfunction : exp_wr

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic issue(input swb_op_t op, input logic hsp, input logic msb, input logic [5:0] len,
                        input logic [31:0] data);
      @(negedge mclk_in);
      cmd_in = '{op, hsp, msb, len, data};
      hs = hsp;
      cmd_valid_in = 1'b1;
      @(negedge mclk_in);
      cmd_valid_in = 1'b0;
      oe_cnt = 0;
      got_done = 1'b0;
      got_err = 1'b0;
      for (int n = 0; n < 40000 && !got_done && !got_err; n++)
      begin
         oe_cnt += int'(line_oe_out === 1'b1);
         got_done = (done_out === 1'b1);
         got_err = (err_out === 1'b1);
         if (!got_done && !got_err)
            @(negedge mclk_in);
      end
   endtask : issue

   task automatic do_reset(input logic hsp, input logic present, input int exp_oe);
      en = present;
      issue(SWB_OP_RESET, hsp, 1'b0, 6'h08, 32'h0000_0000);
      check("reset done", got_done, 32'h1);
      check("reset low cycles", oe_cnt, exp_oe);
      check("line released", line_oe_out, 32'h0);
      check("ready after reset", cmd_ready_out, 32'h1);
      check("presence", presence_out, present);
   endtask : do_reset

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_early;
      issue(SWB_OP_WRITE, 1'b1, 1'b0, 6'h08, 32'h0000_00A5);
      check("early refused", got_err, 32'h1);
      check("early no slot", oe_cnt, 32'h0);
      $display("test early done");
   endtask : t_early

   task automatic t_write;
      logic [31:0] dat [4] = '{32'h0000_00A5, 32'h0000_0003, 32'h0000_0001, 32'h8000_0001};
      logic [5:0]  len [4] = '{6'h08, 6'h04, 6'h01, 6'h20};
      logic [63:0] m;
      int          eo;
      do_reset(1'b0, 1'b1, int'(RST_CYC));
      rd_mode = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         issue(SWB_OP_WRITE, 1'b1, k[0], len[k], dat[k]);
         m = (64'h1 << len[k]) - 64'h1;
         eo = 0;
         for (int i = 0; i < int'(len[k]); i++)
            eo += dat[k][i] ? int'(LOW_HS_CYC) : int'(SLOT_HS_CYC);
         check("write done", got_done, 32'h1);
         check("write bits", wr_q & m[31:0], exp_wr(dat[k], int'(len[k]), k[0]));
         check("write low cycles", oe_cnt, eo);
      end
      issue(SWB_OP_WRITE, 1'b1, 1'b0, 6'h00, 32'h0000_0001);
      check("len 0 refused", got_err, 32'h1);
      issue(SWB_OP_WRITE, 1'b1, 1'b0, 6'h21, 32'h0000_0001);
      check("len 33 refused", got_err, 32'h1);
      $display("test write done");
   endtask : t_write

   task automatic t_absent;
      do_reset(1'b0, 1'b0, int'(RST_CYC));
      issue(SWB_OP_WRITE, 1'b1, 1'b0, 6'h08, 32'h0000_005A);
      check("absent refused", got_err, 32'h1);
      $display("test absent done");
   endtask : t_absent

   task automatic t_read;
      do_reset(1'b1, 1'b1, int'(RSTL_HS_CYC));
      rd_mode = 1'b1;
      issue(SWB_OP_READ, 1'b1, 1'b0, 6'h20, 32'h0000_0000);
      check("read done", got_done, 32'h1);
      issue(SWB_OP_READ, 1'b1, 1'b0, 6'h20, 32'h0000_0000);
      issue(SWB_OP_READ, 1'b1, 1'b0, 6'h08, 32'h0000_0000);
      check("full refused", got_err, 32'h1);
      @(negedge mclk_in);
      check("rd valid", rd_valid_out, 32'h1);
      check("id low word", rd_data_out, DEV_ID[31:0]);
      rd_ready_in = 1'b1;
      @(negedge mclk_in);
      check("id high word", rd_data_out, DEV_ID[63:32]);
      @(negedge mclk_in);
      rd_ready_in = 1'b0;
      check("drained", rd_valid_out, 32'h0);
      issue(SWB_OP_READ, 1'b1, 1'b1, 6'h04, 32'h0000_0000);
      @(negedge mclk_in);
      check("msb read", rd_data_out, exp_wr(DEV_ID[31:0], 4, 1'b0));
      rd_ready_in = 1'b1;
      @(negedge mclk_in);
      rd_ready_in = 1'b0;
      $display("test read done");
   endtask : t_read

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      mclk_in = 1'b0;
      sys_rst_in = 1'b1;
      cmd_valid_in = 1'b0;
      rd_ready_in = 1'b0;
      cmd_in = '0;
      en = 1'b1;
      hs = 1'b0;
      rd_mode = 1'b0;
      repeat (20) @(posedge mclk_in);
      @(negedge mclk_in);
      sys_rst_in = 1'b0;
      t_early();
      t_write();
      t_absent();
      t_read();
      wrap_up();
   end

endmodule : tb_single_wire_bus_decoder
